// [inc/tbs_consts.svh]
/*
 constants of the tuner bias sequencer: offsets, reset values, timing counts.
 assumes a 20 MHz clk_i and a 32-bit classic wishbone register bus.
*/
// How it works
// - a rising io supply level enters startup and loads every register default.
// - that same power-on reset keeps the bus ack and read data, so a pending cycle still ends.
// - no brown-out action; reset re-arms only after the supply went low.
// - defaults: boost code 1011, power field 01 then 00, outputs off.
// - low io supply level forces shutdown, all off, registers lost.
// - after supply rise the block starts alone and settles in active mode.
// - shutdown to active completes within 300 us, 180 us typical.
// - boost switches while high voltage is under reference, stops above it.
// - boost switching averages 2 MHz, spread between 0.8 and 4 MHz.
// - output voltage equals code over 255 times 24 V times two.
// - channel output limited to boosted voltage minus 2 V.
// - turbo drives an offset target for the turbo hold time, then target.
// - each channel chooses turbo, glide or plain switching on its own.
// - glide bit set per channel disables turbo on that channel only.
// - glide reaches its end within 127 steps, step 2 to 64 us.
// - glide steps run without further host writes.
// - boost reference 13 V to 28 V in 1 V steps, 4-bit code.
// - channel code is 7 bits, 128 steps of 188 mV.
// - host may enter low power: outputs and boost off, registers kept.
`ifndef TBS_CONSTS_SVH
`define TBS_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TBS_OFS_ENABLE 8'h00
`define TBS_OFS_TURBO 8'h04
`define TBS_OFS_CODE_A 8'h08
`define TBS_OFS_CODE_B 8'h0c
`define TBS_OFS_BOOST 8'h10
`define TBS_OFS_HOLD 8'h14
`define TBS_OFS_POWER 8'h18
`define TBS_OFS_INDEX 8'h1c
`define TBS_OFS_STATUS 8'h20
// ----------------------------------------
// reset values and field codes
// ----------------------------------------
`define TBS_EN_RST 7'h40
`define TBS_BOOST_RST 4'hb
`define TBS_PWR_ACTIVE 2'h0
`define TBS_PWR_START 2'h1
`define TBS_PWR_LOW 2'h2
`define TBS_PWR_OFF 2'h3
`define TBS_EN_BIT_A 3
`define TBS_SPREAD_BIT 6
// ----------------------------------------
// analog scaling and timing
// ----------------------------------------
`define TBS_VHV_MIN_V 13
`define TBS_HEADROOM_V 2
`define TBS_FULL_CODE 255
`define TBS_DAC_REF_V 24
`define TBS_CLK_HZ 20000000
`define TBS_CLK_NS 50
`define TBS_US_NS 1000
`define TBS_US_CYC (`TBS_US_NS / `TBS_CLK_NS)
`define TBS_START_US 180
`define TBS_START_CYC (`TBS_START_US * `TBS_US_NS / `TBS_CLK_NS)
`define TBS_GLIDE_MIN_US 2
`define TBS_SW_AVG_HZ 2000000
`define TBS_SW_MAX_HZ 4000000
`define TBS_SW_MIN_HZ 800000
`define TBS_SW_AVG_CYC (`TBS_CLK_HZ / `TBS_SW_AVG_HZ)
`define TBS_SW_MIN_CYC (`TBS_CLK_HZ / `TBS_SW_MAX_HZ)
`define TBS_SW_MAX_CYC (`TBS_CLK_HZ / `TBS_SW_MIN_HZ)
`endif

// [inc/tbs_pkg.sv]
/*
 types of the tuner bias sequencer.
 assumes tbs_consts.svh on the include path.
*/
package tbs_pkg;
   // one-hot power states
   typedef enum logic [3:0] {
      TBS_PS_OFF = 4'h1,
      TBS_PS_START = 4'h2,
      TBS_PS_ACTIVE = 4'h4,
      TBS_PS_LOW = 4'h8
   } tbs_pwr_type;

   typedef logic [1:0][6:0] tbs_code_pair_type;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } tbs_wb_req_type;

   typedef struct packed {
      tbs_pwr_type ps;
      logic [1:0] pwr_code;
      logic io_prev;
      logic [11:0] start_cnt;
      logic ack;
      logic [31:0] rdata;
      logic [6:0] en_mask;
      logic [7:0] turbo_cfg;
      logic [3:0] boost_ref;
      logic [7:0] turbo_hold;
      logic [6:0] glide_cfg;
      tbs_code_pair_type target;
      tbs_code_pair_type drive;
      tbs_code_pair_type code_o;
      logic [1:0][7:0] hold_cnt;
      logic [1:0][6:0] step_cnt;
      logic [1:0] oe;
      logic [4:0] us_cnt;
      logic us_tick;
      logic [4:0] sw_cnt;
      logic [4:0] sw_half;
      logic [2:0] sw_idx;
      logic sw_o;
   } tbs_state_type;
endpackage

// [src/tbs_sequencer.sv]
/*
 tuner bias sequencer: power modes, boost on/off regulation with spread
 switching, two 7-bit bias channels with turbo and glide, wishbone regs.
 assumes a 20 MHz clock, synchronous inputs and an external comparator
 that flags the boosted voltage above the selected reference.
*/
`include "tbs_consts.svh"

module tbs_sequencer (
   input wire logic clk_i, // 20 MHz clock
   input wire logic rst_i, // synchronous reset, high
   input wire tbs_pkg::tbs_wb_req_type wb_i, // wishbone request
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic wb_ack_o, // wishbone ack
   input wire logic io_supply_level_i, // io supply present
   input wire logic boost_above_ref_i, // boost voltage above reference
   output logic [3:0] boost_ref_o, // boost reference code
   output logic boost_sw_o, // boost switch gate
   output tbs_pkg::tbs_code_pair_type chan_code_o, // channel codes, b:a
   output logic [1:0] chan_oe_o, // channel drive enables, b:a
   output logic [1:0] power_state_o // power state field
);
   import tbs_pkg::*;

   // ----------------------------------------
   // constants and helpers
   // ----------------------------------------
   // period table averages the nominal rate; entries stay in the spread band
   localparam logic [4:0] SW_PER [0:7] = '{
      5'h05, 5'h0e, 5'h08, 5'h0c, 5'h06, 5'h0f, 5'h0a, 5'h0a
   };

   function automatic tbs_state_type por_vals(input tbs_pwr_type ps);
      tbs_state_type d;
      d = '0;
      d.ps = ps;
      // the power field mirrors the state, so a held reset reads as shutdown
      d.pwr_code = (ps == TBS_PS_OFF) ? `TBS_PWR_OFF : `TBS_PWR_START;
      d.en_mask = `TBS_EN_RST;
      d.boost_ref = `TBS_BOOST_RST;
      return d;
   endfunction

   // highest code whose voltage stays the headroom below the boost level
   function automatic logic [6:0] lim_of(input logic [3:0] r);
      logic [15:0] t;
      t = ((16'(r) + 16'(`TBS_VHV_MIN_V - `TBS_HEADROOM_V))
          * 16'(`TBS_FULL_CODE)) / 16'(2 * `TBS_DAC_REF_V);
      lim_of = (t > 16'h007f) ? 7'h7f : t[6:0];
   endfunction

   function automatic logic [6:0] kick(input logic [6:0] tgt,
                                       input logic [6:0] old,
                                       input logic [3:0] off);
      logic [7:0] t;
      t = 8'(tgt) + 8'(off);
      if (tgt >= old) begin
         kick = (t > 8'h7f) ? 7'h7f : t[6:0];
      end else begin
         kick = (tgt > 7'(off)) ? tgt - 7'(off) : 7'h00;
      end
   endfunction

   tbs_state_type s;
   tbs_state_type n;
   logic acc;
   logic wr;
   logic [6:0] step_us;

   assign acc = wb_i.cyc && wb_i.stb && !s.ack;
   assign wr = acc && wb_i.we && wb_i.sel[0] && (s.ps != TBS_PS_OFF);
   // interval field counts in units of the shortest step
   assign step_us = 7'({2'h0, s.glide_cfg[6:2]} + 7'h01) * 7'(`TBS_GLIDE_MIN_US);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic keep_ack;
      logic pwr_por;
      logic run;
      logic [4:0] per;
      logic [31:0] keep_dat;
      keep_ack = 1'b0;
      pwr_por = 1'b0;
      run = 1'b0;
      per = 5'h00;
      keep_dat = 32'h0000_0000;
      n = s;
      n.ack = 1'b0;
      n.us_tick = 1'b0;
      n.io_prev = io_supply_level_i;

      // microsecond enable
      if (s.us_cnt == 5'(`TBS_US_CYC - 1)) begin
         n.us_cnt = 5'h00;
         n.us_tick = 1'b1;
      end else begin
         n.us_cnt = s.us_cnt + 5'h01;
      end

      // per-channel sequencing
      for (int i = 0; i < 2; i++) begin
         if (s.hold_cnt[i] != 8'h00 && s.us_tick) begin
            n.hold_cnt[i] = s.hold_cnt[i] - 8'h01;
            if (s.hold_cnt[i] == 8'h01) begin
               n.drive[i] = s.target[i];
            end
         end
         if (s.glide_cfg[i] && s.hold_cnt[i] == 8'h00
             && s.drive[i] != s.target[i] && s.us_tick) begin
            if (s.step_cnt[i] >= step_us - 7'h01) begin
               n.step_cnt[i] = 7'h00;
               n.drive[i] = (s.drive[i] < s.target[i]) ? s.drive[i] + 7'h01
                                                       : s.drive[i] - 7'h01;
            end else begin
               n.step_cnt[i] = s.step_cnt[i] + 7'h01;
            end
         end
      end

      // startup countdown
      if (s.ps == TBS_PS_START) begin
         if (s.start_cnt == 12'(`TBS_START_CYC - 1)) begin
            n.ps = TBS_PS_ACTIVE;
            n.start_cnt = 12'h000;
         end else begin
            n.start_cnt = s.start_cnt + 12'h001;
         end
      end

      // bus access
      if (acc) begin
         n.ack = 1'b1;
         case (wb_i.adr)
            `TBS_OFS_ENABLE: n.rdata = {25'h0, s.en_mask};
            `TBS_OFS_TURBO: n.rdata = {24'h0, s.turbo_cfg};
            `TBS_OFS_CODE_A: n.rdata = {25'h0, s.target[0]};
            `TBS_OFS_CODE_B: n.rdata = {25'h0, s.target[1]};
            `TBS_OFS_BOOST: n.rdata = {28'h0, s.boost_ref};
            `TBS_OFS_HOLD: n.rdata = {24'h0, s.turbo_hold};
            `TBS_OFS_POWER: n.rdata = {30'h0, s.pwr_code};
            `TBS_OFS_INDEX: n.rdata = {25'h0, s.glide_cfg};
            `TBS_OFS_STATUS: begin
               n.rdata = {11'h0, s.hold_cnt[1] != 8'h00, s.hold_cnt[0] != 8'h00,
                          s.sw_o, s.oe, 1'b0, s.drive[1], 1'b0, s.drive[0]};
            end
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         case (wb_i.adr)
            `TBS_OFS_ENABLE: n.en_mask = wb_i.dat[6:0];
            `TBS_OFS_TURBO: n.turbo_cfg = wb_i.dat[7:0];
            `TBS_OFS_BOOST: n.boost_ref = wb_i.dat[3:0];
            `TBS_OFS_HOLD: n.turbo_hold = wb_i.dat[7:0];
            `TBS_OFS_INDEX: n.glide_cfg = wb_i.dat[6:0];
            `TBS_OFS_POWER: begin
               if (wb_i.dat[1:0] == `TBS_PWR_START) begin
                  pwr_por = 1'b1;
               end else if (wb_i.dat[1:0] == `TBS_PWR_LOW
                            && s.ps == TBS_PS_ACTIVE) begin
                  n.ps = TBS_PS_LOW;
               end else if (wb_i.dat[1:0] == `TBS_PWR_ACTIVE
                            && s.ps == TBS_PS_LOW) begin
                  n.ps = TBS_PS_ACTIVE;
               end
            end
            default: ;
         endcase
         for (int i = 0; i < 2; i++) begin
            if (wb_i.adr == (i == 0 ? `TBS_OFS_CODE_A : `TBS_OFS_CODE_B)) begin
               n.target[i] = wb_i.dat[6:0];
               n.step_cnt[i] = 7'h00;
               n.hold_cnt[i] = 8'h00;
               if (s.glide_cfg[i]) begin
                  n.drive[i] = s.drive[i];
               end else if (s.turbo_cfg[i] && s.turbo_hold != 8'h00) begin
                  n.drive[i] = kick(wb_i.dat[6:0], s.drive[i], s.turbo_cfg[7:4]);
                  n.hold_cnt[i] = s.turbo_hold;
               end else begin
                  n.drive[i] = wb_i.dat[6:0];
               end
            end
         end
      end

      // supply handling; the bus answer and its data survive so a pending cycle ends
      keep_ack = n.ack;
      keep_dat = n.rdata;
      if (!io_supply_level_i) begin
         n = por_vals(TBS_PS_OFF);
         n.ack = keep_ack;
         n.rdata = keep_dat;
      end else if (!s.io_prev || pwr_por) begin
         n = por_vals(TBS_PS_START);
         n.io_prev = 1'b1;
         n.ack = keep_ack;
         n.rdata = keep_dat;
      end

      // boost switching, only while the converter is on
      run = (n.ps == TBS_PS_START) || (n.ps == TBS_PS_ACTIVE);
      per = s.en_mask[`TBS_SPREAD_BIT] ? SW_PER[s.sw_idx] : 5'(`TBS_SW_AVG_CYC);
      if (!run) begin
         n.sw_cnt = 5'h00;
      end else if (s.sw_cnt != 5'h00) begin
         n.sw_cnt = s.sw_cnt - 5'h01;
      end else if (!boost_above_ref_i) begin
         n.sw_cnt = per - 5'h01;
         n.sw_half = per >> 1;
         n.sw_idx = s.sw_idx + 3'h1;
      end
      n.sw_o = (n.sw_cnt != 5'h00) && (n.sw_cnt >= n.sw_half);

      // registered outputs
      case (n.ps)
         TBS_PS_ACTIVE: n.pwr_code = `TBS_PWR_ACTIVE;
         TBS_PS_START: n.pwr_code = `TBS_PWR_START;
         TBS_PS_LOW: n.pwr_code = `TBS_PWR_LOW;
         default: n.pwr_code = `TBS_PWR_OFF;
      endcase
      for (int i = 0; i < 2; i++) begin
         n.code_o[i] = (n.drive[i] > lim_of(n.boost_ref)) ? lim_of(n.boost_ref)
                                                          : n.drive[i];
         n.oe[i] = (n.ps == TBS_PS_ACTIVE) && n.en_mask[`TBS_EN_BIT_A - i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= por_vals(TBS_PS_OFF);
      end else begin
         s <= n;
      end
   end

   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign boost_ref_o = s.boost_ref;
   assign boost_sw_o = s.sw_o;
   assign chan_code_o = s.code_o;
   assign chan_oe_o = s.oe;
   assign power_state_o = s.pwr_code;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence supply_rise_s;
      io_supply_level_i && !s.io_prev;
   endsequence

   sequence turbo_wr_s;
      wr && wb_i.adr == `TBS_OFS_CODE_A && s.turbo_cfg[0]
         && !s.glide_cfg[0] && s.turbo_hold != 8'h00;
   endsequence

   sequence glide_step_s;
      s.glide_cfg[1] && s.hold_cnt[1] == 8'h00 && s.drive[1] != s.target[1]
         && s.us_tick && s.step_cnt[1] >= step_us - 7'h01 && !wr
         && io_supply_level_i && s.io_prev;
   endsequence

   sequence plain_wr_s;
      wr && wb_i.adr == `TBS_OFS_CODE_A && !s.glide_cfg[0]
         && (!s.turbo_cfg[0] || s.turbo_hold == 8'h00) && io_supply_level_i && s.io_prev;
   endsequence

   supply_off_a: assert property (!io_supply_level_i |=>
      s.ps == TBS_PS_OFF && s.oe == 2'h0 && !s.sw_o && s.target[0] == 7'h00)
      else $error("low supply did not force shutdown");

   por_defaults_a: assert property (supply_rise_s |=>
      s.ps == TBS_PS_START && s.boost_ref == `TBS_BOOST_RST
      && s.en_mask == `TBS_EN_RST && power_state_o == `TBS_PWR_START)
      else $error("supply rise did not load defaults");

   no_brownout_a: assert property (s.ps == TBS_PS_ACTIVE && io_supply_level_i
      && s.io_prev && !(wr && wb_i.adr == `TBS_OFS_POWER) |=> s.ps != TBS_PS_START)
      else $error("reset fired without supply low");

   start_bound_a: assert property (s.ps == TBS_PS_START |->
      s.start_cnt < 12'(`TBS_START_CYC))
      else $error("startup exceeds its time");

   start_done_a: assert property (s.ps == TBS_PS_START && io_supply_level_i
      && s.start_cnt == 12'(`TBS_START_CYC - 1) && !wr |=> s.ps == TBS_PS_ACTIVE
      ##1 power_state_o == `TBS_PWR_ACTIVE || s.ps != TBS_PS_ACTIVE)
      else $error("startup did not reach active");

   boost_stop_a: assert property (s.sw_cnt == 5'h00 && boost_above_ref_i
      |=> !boost_sw_o)
      else $error("boost switching above reference");

   boost_period_a: assert property ($rose(boost_sw_o) |->
      s.sw_cnt < 5'(`TBS_SW_MAX_CYC) && s.sw_cnt >= 5'(`TBS_SW_MIN_CYC - 2))
      else $error("boost period outside spread band");

   headroom_a: assert property (chan_code_o[0] <= lim_of(s.boost_ref)
      && chan_code_o[1] <= lim_of(s.boost_ref))
      else $error("channel code above headroom limit");

   turbo_hold_a: assert property (turbo_wr_s ##1 io_supply_level_i |->
      s.hold_cnt[0] == s.turbo_hold)
      else $error("turbo hold not loaded");

   glide_noturbo_a: assert property (wr && wb_i.adr == `TBS_OFS_CODE_B
      && s.glide_cfg[1] |=> s.hold_cnt[1] == 8'h00)
      else $error("turbo ran on a gliding channel");

   glide_step_a: assert property (glide_step_s |=>
      s.drive[1] == $past(s.drive[1]) + 7'h01
      || s.drive[1] == $past(s.drive[1]) - 7'h01)
      else $error("glide step not one code");

   plain_code_a: assert property (plain_wr_s |=>
      s.drive[0] == $past(wb_i.dat[6:0]) && s.target[0] == $past(wb_i.dat[6:0]))
      else $error("plain code write not applied");

   spread_off_a: assert property ($rose(boost_sw_o) && !$past(s.en_mask[`TBS_SPREAD_BIT])
      |-> s.sw_cnt == 5'(`TBS_SW_AVG_CYC - 1))
      else $error("fixed boost period wrong");

   low_enter_a: assert property (wr && wb_i.adr == `TBS_OFS_POWER
      && wb_i.dat[1:0] == `TBS_PWR_LOW && s.ps == TBS_PS_ACTIVE && io_supply_level_i
      && s.io_prev |=> s.ps == TBS_PS_LOW && power_state_o == `TBS_PWR_LOW)
      else $error("low power request ignored");

   regs_kept_a: assert property (s.ps == TBS_PS_LOW && io_supply_level_i && !wr |=>
      s.target == $past(s.target) && s.boost_ref == $past(s.boost_ref))
      else $error("registers lost in low power");

   soft_reset_a: assert property (wr && wb_i.adr == `TBS_OFS_POWER
      && wb_i.dat[1:0] == `TBS_PWR_START && io_supply_level_i |=> s.ps == TBS_PS_START
      && s.target == '0 && s.en_mask == `TBS_EN_RST && wb_ack_o)
      else $error("software reset did not reload defaults");

   low_power_a: assert property (s.ps == TBS_PS_LOW |=>
      s.ps == TBS_PS_OFF || s.ps == TBS_PS_START
      || (chan_oe_o == 2'h0 && !boost_sw_o) || s.ps == TBS_PS_ACTIVE)
      else $error("outputs live in low power");

endmodule // tbs_sequencer

// [test/tbs_boost_model.sv]
/*
 behavioural model of the boost output and its level comparator.
 assumes the gate pulses of the sequencer and a bench that picks the mode.
*/
module tbs_boost_model (
   input wire logic clk_i, // bench clock
   input wire logic rst_i, // synchronous reset, high
   input wire logic sw_i, // boost switch gate
   input wire logic [1:0] mode_i, // 0 real, 1 held below, 2 held above
   output logic above_o // boosted level above reference
);
   logic [7:0] lvl_r;
   logic sw_r;
   logic [2:0] leak_r;

   // ----------------------------------------
   // charge and drain
   // ----------------------------------------
   // the level only rises with gate pulses, so a dead gate lets it sag
   always_ff @(posedge clk_i) begin
      sw_r <= sw_i;
      if (rst_i) begin
         lvl_r <= 8'h00;
         leak_r <= 3'h0;
      end else begin
         leak_r <= leak_r + 3'h1;
         if (sw_i && !sw_r && lvl_r < 8'hf0) begin
            lvl_r <= lvl_r + 8'h04;
         end else if (leak_r == 3'h0 && lvl_r != 8'h00) begin
            lvl_r <= lvl_r - 8'h01;
         end
      end
   end

   assign above_o = (mode_i == 2'h2) || (mode_i == 2'h0 && lvl_r >= 8'h40);
endmodule // tbs_boost_model

// [test/tb_top.sv]
/*
 self-checking bench of the tuner bias sequencer: power modes, boost gate,
 channels in plain, turbo and glide use, headroom clamp, supply loss.
 assumes tbs_pkg compiled first and tbs_consts.svh on the include path.
*/
`include "tbs_consts.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import tbs_pkg::*;

   logic clk_i;
   logic rst_i;
   logic io_r;
   logic above;
   logic [1:0] mode_r;
   tbs_wb_req_type wb_r;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] boost_ref_o;
   logic boost_sw_o;
   tbs_code_pair_type chan_code_o;
   logic [1:0] chan_oe_o;
   logic [1:0] power_state_o;
   int failures;
   int tests_run;

   tbs_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_r), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .io_supply_level_i(io_r), .boost_above_ref_i(above),
      .boost_ref_o(boost_ref_o), .boost_sw_o(boost_sw_o), .chan_code_o(chan_code_o),
      .chan_oe_o(chan_oe_o), .power_state_o(power_state_o));

   tbs_boost_model i_boost (.clk_i(clk_i), .rst_i(rst_i), .sw_i(boost_sw_o), .mode_i(mode_r),
      .above_o(above));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic give_up;
      failures++;
      end_of_test();
   endtask

   // entered just after a rising edge; returns just after one
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      wb_r <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) give_up();
      q = wb_dat_o;
      wb_r <= '{default: '0};
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic wait_ps(input logic [1:0] v, input int lim, output int n);
      n = 0;
      while (power_state_o !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (power_state_o !== v) give_up();
   endtask

   task automatic wait_code(input int c, input logic [6:0] v, input int lim, output int n);
      n = 0;
      while (chan_code_o[c] !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (chan_code_o[c] !== v) give_up();
   endtask

   task automatic rises(input int len, output int cnt, output int gmin, output int gmax);
      int gap;
      logic p;
      cnt = 0;
      gmin = 999;
      gmax = 0;
      gap = 0;
      p = boost_sw_o;
      repeat (len) begin
         @(posedge clk_i);
         gap++;
         if (boost_sw_o === 1'b1 && p !== 1'b1) begin
            if (cnt > 0 && gap < gmin) gmin = gap;
            if (cnt > 0 && gap > gmax) gmax = gap;
            cnt++;
            gap = 0;
         end
         p = boost_sw_o;
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_startup;
      int n;
      wait_ps(`TBS_PWR_START, 10, n);
      wait_ps(`TBS_PWR_ACTIVE, 7000, n);
      chk(n <= 6000, 1);
      chk(boost_ref_o, `TBS_BOOST_RST);
      chk(chan_oe_o, 2'b00);
      rd(`TBS_OFS_ENABLE, `TBS_EN_RST);
      rd(`TBS_OFS_BOOST, `TBS_BOOST_RST);
      $display("test startup done");
   endtask

   task automatic t_plain;
      wr(`TBS_OFS_ENABLE, 32'h48);
      wr(`TBS_OFS_CODE_A, 32'h0a);
      chk(chan_code_o[0], 7'h0a);
      chk(chan_oe_o, 2'b01);
      wr(`TBS_OFS_CODE_A, 32'h7f);
      chk(chan_code_o[0], 7'h74);
      rd(8'h40, 32'h0);
      rd(`TBS_OFS_CODE_A, 32'h7f);
      $display("test plain done");
   endtask

   task automatic t_boost;
      int c, lo, hi;
      mode_r <= 2'h1;
      rises(400, c, lo, hi);
      chk(c >= 16 && c <= 80, 1);
      chk(lo >= 5 && hi <= 25, 1);
      wr(`TBS_OFS_ENABLE, 32'h08);
      rises(200, c, lo, hi);
      chk(lo, `TBS_SW_AVG_CYC);
      chk(hi, `TBS_SW_AVG_CYC);
      wr(`TBS_OFS_ENABLE, 32'h48);
      mode_r <= 2'h2;
      repeat (20) @(posedge clk_i);
      rises(100, c, lo, hi);
      chk(c, 0);
      mode_r <= 2'h0;
      wr(`TBS_OFS_POWER, {30'h0, `TBS_PWR_LOW});
      chk(power_state_o, `TBS_PWR_LOW);
      mode_r <= 2'h1;
      rises(100, c, lo, hi);
      chk(c, 0);
      chk(chan_oe_o, 2'b00);
      rd(`TBS_OFS_CODE_A, 32'h7f);
      wr(`TBS_OFS_POWER, {30'h0, `TBS_PWR_ACTIVE});
      mode_r <= 2'h0;
      chk(chan_oe_o, 2'b01);
      $display("test boost done");
   endtask

   task automatic t_turbo;
      int n;
      wr(`TBS_OFS_BOOST, 32'hb);
      wr(`TBS_OFS_HOLD, 32'h3);
      wr(`TBS_OFS_TURBO, 32'h31);
      wr(`TBS_OFS_CODE_A, 32'h28);
      chk(chan_code_o[0], 7'h25);
      wait_code(0, 7'h28, 200, n);
      chk(n >= 30 && n <= 80, 1);
      wr(`TBS_OFS_CODE_A, 32'h30);
      chk(chan_code_o[0], 7'h33);
      wait_code(0, 7'h30, 200, n);
      chk(n >= 30 && n <= 80, 1);
      $display("test turbo done");
   endtask

   task automatic t_glide;
      logic [6:0] last;
      int ch, t, t0;
      wr(`TBS_OFS_TURBO, 32'h33);
      wr(`TBS_OFS_ENABLE, 32'h4c);
      wr(`TBS_OFS_INDEX, 32'h02);
      last = chan_code_o[1];
      wr(`TBS_OFS_CODE_B, 32'h04);
      ch = 0;
      t0 = 0;
      for (t = 0; t < 400; t++) begin
         if (chan_code_o[1] !== last) begin
            chk(chan_code_o[1], last + 7'h01);
            if (ch == 0) t0 = t;
            if (ch == 3) chk(t - t0, 120);
            last = chan_code_o[1];
            ch++;
         end
         @(posedge clk_i);
      end
      chk(ch, 4);
      chk(chan_code_o[1], 7'h04);
      wr(`TBS_OFS_CODE_A, 32'h20);
      chk(chan_code_o[0], 7'h1d);
      $display("test glide done");
   endtask

   task automatic t_clamp;
      wr(`TBS_OFS_TURBO, 32'h0);
      wr(`TBS_OFS_BOOST, 32'h0);
      wr(`TBS_OFS_CODE_A, 32'h7f);
      repeat (3) @(posedge clk_i);
      chk(boost_ref_o, 4'h0);
      chk(chan_code_o[0], 7'((0 + 11) * 255 / 48));
      $display("test clamp done");
   endtask

   task automatic t_soft;
      int n;
      wr(`TBS_OFS_POWER, {30'h0, `TBS_PWR_START});
      chk(power_state_o, `TBS_PWR_START);
      chk(chan_oe_o, 2'b00);
      rd(`TBS_OFS_TURBO, 32'h0);
      rd(`TBS_OFS_CODE_A, 32'h0);
      wait_ps(`TBS_PWR_ACTIVE, 7000, n);
      chk(n <= 6000, 1);
      $display("test soft reset done");
   endtask

   task automatic t_supply;
      int n;
      io_r <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(power_state_o, `TBS_PWR_OFF);
      chk(chan_oe_o, 2'b00);
      rd(`TBS_OFS_CODE_A, 32'h0);
      rd(`TBS_OFS_ENABLE, `TBS_EN_RST);
      io_r <= 1'b1;
      wait_ps(`TBS_PWR_START, 10, n);
      wait_ps(`TBS_PWR_ACTIVE, 7000, n);
      chk(boost_ref_o, `TBS_BOOST_RST);
      rd(`TBS_OFS_CODE_B, 32'h0);
      rd(`TBS_OFS_ENABLE, `TBS_EN_RST);
      $display("test supply done");
   endtask

   initial begin
      rst_i = 1'b1;
      io_r = 1'b1;
      mode_r = 2'h0;
      wb_r = '{default: '0};
      failures = 0;
      tests_run = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_startup();
      t_plain();
      t_boost();
      t_turbo();
      t_glide();
      t_clamp();
      t_soft();
      t_supply();
      end_of_test();
   end
endmodule // tb_top
